// >>> verilog/pis_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants of the process image handshake
package pis_pkg;

  // Clock and time base
  localparam int unsigned CLK_MHZ        = 25;             // System clock rate
  localparam int unsigned US_CLKS        = CLK_MHZ;        // Cycles per microsecond
  localparam int unsigned CYCLE_US       = 1000;           // Bus cycle period
  localparam int unsigned CYCLE_CLKS     = CYCLE_US * US_CLKS;
  localparam logic [31:0] BUS_TMO_DEF_US = 32'd200000;     // Bus timeout, 200 ms

  // Shared coupling memory words
  localparam int unsigned AW      = 3;                     // Word index width
  localparam int unsigned DW      = 16;                    // Word width
  localparam logic [2:0]  W_START = 3'h0;                  // Function start word
  localparam logic [2:0]  W_STAT  = 3'h1;                  // Function status word
  localparam logic [2:0]  W_IN    = 3'h2;                  // Input data word
  localparam logic [2:0]  W_OUT   = 3'h3;                  // Output data word
  localparam logic [2:0]  W_IRQH  = 3'h4;                  // Interrupt toward host
  localparam logic [2:0]  W_IRQD  = 3'h5;                  // Interrupt toward device
  localparam logic [2:0]  W_MBOX  = 3'h6;                  // Request word port
  localparam int unsigned LOCK_BIT   = 15;                 // Lock flag position
  localparam int unsigned BUSACT_BIT = 0;                  // Bus activity position

  // Interrupt codes and mode request
  localparam logic [15:0] IRQ_TO_HOST   = 16'h0010;
  localparam logic [15:0] IRQ_TO_DEV    = 16'h0020;
  localparam logic [15:0] REQ_SET_VALUE = 16'h0750;
  localparam logic [15:0] REQ_NPARAM    = 16'h0004;
  localparam logic [15:0] REQ_NVAR      = 16'h0001;
  localparam logic [15:0] VAR_OPMODE    = 16'h2200;
  localparam logic [15:0] MODE_ON       = 16'h0600;
  localparam logic [15:0] MODE_OFF      = 16'h0000;
  localparam logic [2:0]  MB_LAST       = 3'h4;            // Index of value word

  // Host register map (word index = byte address / 4)
  localparam int unsigned AXI_AW   = 5;
  localparam logic [2:0]  REG_CTRL = 3'h0;
  localparam logic [2:0]  REG_STAT = 3'h1;
  localparam logic [2:0]  REG_ADDR = 3'h2;
  localparam logic [2:0]  REG_DATA = 3'h3;
  localparam logic [2:0]  REG_ACK  = 3'h4;
  localparam int unsigned CTRL_LOCK  = 0;
  localparam int unsigned CTRL_PULSE = 1;
  localparam int unsigned STAT_GRANT = 0;
  localparam int unsigned STAT_IRQ   = 1;
  localparam int unsigned STAT_WAIT  = 2;
  localparam int unsigned STAT_BUS   = 3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Device cycle phase
  typedef enum logic {PH_RUN = 1'b0, PH_WAIT = 1'b1} pis_phase_t;

  // Host sequencer state
  typedef enum logic [1:0]
  {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01,
    H_MB   = 2'b10,
    H_ACK  = 2'b11
  } pis_hstate_t;

  // Word of the mode-setting request at a given index
  function automatic logic [15:0] req_word(input logic [2:0] idx, input logic on);
    logic [15:0] w;
    w = on ? MODE_ON : MODE_OFF;
    case (idx)
      3'h0:    w = REQ_SET_VALUE;
      3'h1:    w = REQ_NPARAM;
      3'h2:    w = REQ_NVAR;
      3'h3:    w = VAR_OPMODE;
      default: w = on ? MODE_ON : MODE_OFF;
    endcase
    return w;
  endfunction

endpackage

// >>> verilog/pis_link_if.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Host access port of the shared coupling memory
interface pis_link_if;
  logic        req;    // One-cycle access strobe
  logic        we;     // Write when high, read when low
  logic [2:0]  addr;   // Word index
  logic [15:0] wdata;  // Write data
  logic [15:0] rdata;  // Read data, valid one cycle after req

  // Device end owns the memory
  modport dev
  (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output rdata
  );

  // Host end issues accesses
  modport hst
  (
    output req,
    output we,
    output addr,
    output wdata,
    input  rdata
  );
endinterface

// >>> verilog/pis_dev_end.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Device end: shared memory, bus cycles, lock and pulse handshakes

module pis_dev_end
#(
  parameter int unsigned CYCLE_CLKS = pis_pkg::CYCLE_CLKS  // Bus cycle length
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  pis_link_if.dev          link,
  input  wire logic        bus_run,
  input  wire logic        tmo_load,
  input  wire logic [31:0] tmo_us,
  input  wire logic [15:0] field_in,
  output logic      [15:0] field_out,
  output logic             cycle_done,
  output logic             sync_err,
  output logic             pulse_mode,
  output logic             lock_granted
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0][15:0]    mem;        // Shared coupling memory
    logic                lock_prev;  // Last sampled request flag
    logic                granted;    // Lock granted
    logic                pulse;      // Pulse mode on
    logic [2:0]          mb_idx;     // Request word index
    logic                mb_ok;      // Request header matched so far
    pis_pkg::pis_phase_t ph;         // Cycle phase
    logic [31:0]         cyc_cnt;    // Clocks into bus cycle
    logic [7:0]          us_cnt;     // Microsecond divider
    logic [31:0]         app_cnt;    // Microseconds waiting for host
    logic [31:0]         tmo;        // Bus timeout in microseconds
    logic [15:0]         rdata;      // Link read data
    logic [15:0]         out;        // Outputs taken for the field
    logic                done;       // Bus cycle finished
    logic                err;        // Synchronization error
  } pis_dev_st_t;

  pis_dev_st_t s_r;      // Registered state
  pis_dev_st_t s_nxt;    // Next state
  logic        us_tick;  // One-cycle microsecond enable
  logic        run;      // Bus cycles running
  logic        lock_now; // Current request flag

  assign us_tick  = (s_r.us_cnt == 8'(pis_pkg::US_CLKS - 1));
  assign run      = bus_run && !s_r.err;
  assign lock_now = s_r.mem[pis_pkg::W_START][pis_pkg::LOCK_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  // Link access, lock edges, bus cycle and pulse handshake
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.us_cnt = us_tick ? 8'h00 : s_r.us_cnt + 8'h01;
    // Timeout reload from the user side
    if (tmo_load)
    begin
      s_nxt.tmo = tmo_us;
    end
    // Host access to the shared memory
    if (link.req)
    begin
      if (!link.we)
      begin
        s_nxt.rdata = s_r.mem[link.addr];
      end
      else if (link.addr == pis_pkg::W_MBOX)
      begin
        // Mode request arrives one word at a time
        s_nxt.mb_idx = (s_r.mb_idx == pis_pkg::MB_LAST) ? 3'h0 : s_r.mb_idx + 3'h1;
        if (s_r.mb_idx != pis_pkg::MB_LAST)
        begin
          s_nxt.mb_ok = ((s_r.mb_idx == 3'h0) || s_r.mb_ok)
                      && (link.wdata == pis_pkg::req_word(s_r.mb_idx, 1'b0));
        end
        else if (s_r.mb_ok && link.wdata == pis_pkg::MODE_ON)
        begin
          s_nxt.pulse = 1'b1;
        end
        else if (s_r.mb_ok && link.wdata == pis_pkg::MODE_OFF)
        begin
          s_nxt.pulse = 1'b0;
        end
      end
      else if (link.addr != pis_pkg::W_STAT)
      begin
        // Status word belongs to the device alone
        s_nxt.mem[link.addr] = link.wdata;
      end
    end
    // Bus activity shown to the host
    s_nxt.mem[pis_pkg::W_STAT][pis_pkg::BUSACT_BIT] = run;
    // Lock handshake, frozen while the bus stands
    if (run)
    begin
      s_nxt.lock_prev = lock_now;
      if (lock_now && !s_r.lock_prev)
      begin
        // Updates are atomic, so the last cycle is already complete
        s_nxt.granted = 1'b1;
        s_nxt.mem[pis_pkg::W_STAT][pis_pkg::LOCK_BIT] = 1'b1;
      end
      else if (!lock_now && s_r.lock_prev)
      begin
        // Take the host outputs, then release the flag
        s_nxt.out = s_r.mem[pis_pkg::W_OUT];
        s_nxt.granted = 1'b0;
        s_nxt.mem[pis_pkg::W_STAT][pis_pkg::LOCK_BIT] = 1'b0;
      end
    end
    // Bus cycle sequencing
    if (!run)
    begin
      // Stopped bus: no cycles, no interrupt exchange
      s_nxt.ph      = pis_pkg::PH_RUN;
      s_nxt.cyc_cnt = 32'h0000_0000;
      s_nxt.app_cnt = 32'h0000_0000;
      if (!bus_run)
      begin
        s_nxt.err = 1'b0;
      end
    end
    else
    begin
      unique case (s_r.ph)
        pis_pkg::PH_RUN:
        begin
          if (s_r.cyc_cnt == CYCLE_CLKS - 1)
          begin
            s_nxt.cyc_cnt = 32'h0000_0000;
            s_nxt.done    = 1'b1;
            if (!s_r.granted)
            begin
              // Image refreshed once per cycle, in a single edge
              s_nxt.mem[pis_pkg::W_IN] = field_in;
              if (!s_r.pulse)
              begin
                s_nxt.out = s_r.mem[pis_pkg::W_OUT];
              end
            end
            if (s_r.pulse)
            begin
              // Inputs written in this same update unless granted, code after them
              s_nxt.mem[pis_pkg::W_IRQH] = pis_pkg::IRQ_TO_HOST;
              s_nxt.ph      = pis_pkg::PH_WAIT;
              s_nxt.app_cnt = 32'h0000_0000;
            end
          end
          else
          begin
            s_nxt.cyc_cnt = s_r.cyc_cnt + 32'h0000_0001;
          end
        end
        pis_pkg::PH_WAIT:
        begin
          if (s_r.mem[pis_pkg::W_IRQD] == pis_pkg::IRQ_TO_DEV)
          begin
            // Host answered: take outputs, start next cycle
            s_nxt.mem[pis_pkg::W_IRQD] = 16'h0000;
            s_nxt.out = s_r.mem[pis_pkg::W_OUT];
            s_nxt.ph  = pis_pkg::PH_RUN;
          end
          else if (us_tick)
          begin
            // Application timeout is half the bus timeout
            s_nxt.app_cnt = s_r.app_cnt + 32'h0000_0001;
            if (s_nxt.app_cnt >= (s_r.tmo >> 1))
            begin
              s_nxt.err = 1'b1;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  // Synchronous reset to idle, default timeout
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r     <= '0;
      s_r.tmo <= pis_pkg::BUS_TMO_DEF_US;
      s_r.ph  <= pis_pkg::PH_RUN;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.rdata   = s_r.rdata;
  assign field_out    = s_r.out;
  assign cycle_done   = s_r.done;
  assign sync_err     = s_r.err;
  assign pulse_mode   = s_r.pulse;
  assign lock_granted = s_r.granted;

endmodule // pis_dev_end

// >>> verilog/pis_hst_end.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Host end: AXI4-Lite registers driving the shared memory port
module pis_hst_end
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [4:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [4:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  pis_link_if.hst          link
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic        req;
    logic        we;
    logic [2:0]  addr;
    logic [15:0] wd;
  } pis_lcmd_t;

  typedef struct packed {
    pis_pkg::pis_hstate_t st;       // Sequencer state
    logic [1:0]           ctrl;     // Lock and pulse requests
    logic [2:0]           addr;     // Memory word for data access
    logic                 lk_sent;  // Request flag as written
    logic                 md_sent;  // Mode as last requested
    logic                 ack_pend; // Answer to send
    logic                 irq_seen; // Device code seen
    logic                 grant;    // Granted flag as polled
    logic                 busact;   // Bus activity as polled
    logic                 poll_sel; // Next poll target
    logic                 is_poll;  // Wait belongs to a poll
    logic                 dly;      // Read latency stage
    logic [2:0]           mb_i;     // Request word index
    pis_lcmd_t            lk;       // Registered link command
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
  } pis_hst_st_t;

  pis_hst_st_t s_r;    // Registered state
  pis_hst_st_t s_nxt;  // Next state
  logic        idle;   // Sequencer free
  logic        wr_go;  // Write taken this edge
  logic        rd_go;  // Read taken this edge
  logic [2:0]  aw_idx; // Write register index
  logic [2:0]  ar_idx; // Read register index

  // Link command builder
  function automatic pis_lcmd_t lcmd(input logic we, input logic [2:0] a,
                                     input logic [15:0] d);
    pis_lcmd_t c;
    c.req  = 1'b1;
    c.we   = we;
    c.addr = a;
    c.wd   = d;
    return c;
  endfunction

  // Image access allowed by the lock state
  function automatic logic img_ok(input logic [2:0] a, input logic we,
                                  input logic lk, input logic gr);
    logic img;
    img = (a == pis_pkg::W_IN) || (a == pis_pkg::W_OUT);
    return !(img && lk && !gr)
        && !(we && a == pis_pkg::W_OUT && !lk && gr);
  endfunction

  assign idle   = (s_r.st == pis_pkg::H_IDLE);
  assign aw_idx = awaddr[4:2];
  assign ar_idx = araddr[4:2];
  assign wr_go  = awvalid && wvalid && !s_r.bvalid && idle
               && (aw_idx != pis_pkg::REG_DATA || img_ok(s_r.addr, 1'b1, s_r.lk_sent, s_r.grant));
  assign rd_go  = !wr_go && arvalid && !s_r.rvalid && idle
               && (ar_idx != pis_pkg::REG_DATA || img_ok(s_r.addr, 1'b0, s_r.lk_sent, s_r.grant));

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  // Bus slave, lock driver, request sender and polling
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.lk.req = 1'b0;
    if (s_r.bvalid && bready)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (wr_go)
    begin
      // Write taken; partial strobes leave registers unchanged
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = pis_pkg::RESP_OKAY;
      case (aw_idx)
        pis_pkg::REG_CTRL: if (&wstrb) s_nxt.ctrl = wdata[1:0];
        pis_pkg::REG_ADDR: if (&wstrb) s_nxt.addr = wdata[2:0];
        pis_pkg::REG_DATA: if (&wstrb) s_nxt.lk = lcmd(1'b1, s_r.addr, wdata[15:0]);
        pis_pkg::REG_ACK:
        begin
          if (&wstrb)
          begin
            s_nxt.ack_pend = 1'b1;
            s_nxt.irq_seen = 1'b0;
          end
        end
        pis_pkg::REG_STAT: s_nxt.bresp = pis_pkg::RESP_OKAY;
        default:           s_nxt.bresp = pis_pkg::RESP_SLVERR;
      endcase
    end
    else if (rd_go)
    begin
      // Register reads answer at once, memory reads after the link
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = pis_pkg::RESP_OKAY;
      s_nxt.rdata  = 32'h0000_0000;
      case (ar_idx)
        pis_pkg::REG_CTRL: s_nxt.rdata[1:0] = s_r.ctrl;
        pis_pkg::REG_ADDR: s_nxt.rdata[2:0] = s_r.addr;
        pis_pkg::REG_ACK:  s_nxt.rresp = pis_pkg::RESP_OKAY;
        pis_pkg::REG_STAT:
        begin
          s_nxt.rdata[pis_pkg::STAT_GRANT] = s_r.grant;
          s_nxt.rdata[pis_pkg::STAT_IRQ]   = s_r.irq_seen;
          s_nxt.rdata[pis_pkg::STAT_WAIT]  = s_r.lk_sent && !s_r.grant;
          s_nxt.rdata[pis_pkg::STAT_BUS]   = s_r.busact;
        end
        pis_pkg::REG_DATA:
        begin
          s_nxt.rvalid  = 1'b0;
          s_nxt.lk      = lcmd(1'b0, s_r.addr, 16'h0000);
          s_nxt.st      = pis_pkg::H_WAIT;
          s_nxt.is_poll = 1'b0;
          s_nxt.dly     = 1'b0;
        end
        default:           s_nxt.rresp = pis_pkg::RESP_SLVERR;
      endcase
    end
    else
    begin
      unique case (s_r.st)
        pis_pkg::H_IDLE:
        begin
          if (s_r.ctrl[pis_pkg::CTRL_LOCK] != s_r.lk_sent)
          begin
            // Only the host writes the request flag
            s_nxt.lk = lcmd(1'b1, pis_pkg::W_START,
                            {s_r.ctrl[pis_pkg::CTRL_LOCK], 15'h0000});
            s_nxt.lk_sent = s_r.ctrl[pis_pkg::CTRL_LOCK];
            // A fresh request forgets an old grant; a release keeps it
            // until polled low, so output writes stay held meanwhile
            if (s_r.ctrl[pis_pkg::CTRL_LOCK])
            begin
              s_nxt.grant = 1'b0;
            end
          end
          else if (s_r.ctrl[pis_pkg::CTRL_PULSE] != s_r.md_sent)
          begin
            s_nxt.st      = pis_pkg::H_MB;
            s_nxt.mb_i    = 3'h0;
            s_nxt.md_sent = s_r.ctrl[pis_pkg::CTRL_PULSE];
          end
          else if (s_r.ack_pend)
          begin
            // Clear the device code before answering
            s_nxt.lk       = lcmd(1'b1, pis_pkg::W_IRQH, 16'h0000);
            s_nxt.st       = pis_pkg::H_ACK;
            s_nxt.ack_pend = 1'b0;
          end
          else
          begin
            // Poll status and interrupt words in turn
            s_nxt.lk = lcmd(1'b0, s_r.poll_sel ? pis_pkg::W_IRQH : pis_pkg::W_STAT, 16'h0000);
            s_nxt.poll_sel = !s_r.poll_sel;
            s_nxt.st       = pis_pkg::H_WAIT;
            s_nxt.is_poll  = 1'b1;
            s_nxt.dly      = 1'b0;
          end
        end
        pis_pkg::H_WAIT:
        begin
          // Read data stands two edges after the command
          if (!s_r.dly)
          begin
            s_nxt.dly = 1'b1;
          end
          else
          begin
            s_nxt.st = pis_pkg::H_IDLE;
            if (!s_r.is_poll)
            begin
              s_nxt.rdata  = {16'h0000, link.rdata};
              s_nxt.rresp  = pis_pkg::RESP_OKAY;
              s_nxt.rvalid = 1'b1;
            end
            else if (s_r.lk.addr == pis_pkg::W_STAT)
            begin
              s_nxt.grant  = link.rdata[pis_pkg::LOCK_BIT];
              s_nxt.busact = link.rdata[pis_pkg::BUSACT_BIT];
            end
            else if (link.rdata == pis_pkg::IRQ_TO_HOST)
            begin
              s_nxt.irq_seen = 1'b1;
            end
          end
        end
        pis_pkg::H_MB:
        begin
          // Mode request, one word per cycle
          s_nxt.lk = lcmd(1'b1, pis_pkg::W_MBOX,
                          pis_pkg::req_word(s_r.mb_i, s_r.md_sent));
          s_nxt.mb_i = s_r.mb_i + 3'h1;
          if (s_r.mb_i == pis_pkg::MB_LAST)
          begin
            s_nxt.st = pis_pkg::H_IDLE;
          end
        end
        pis_pkg::H_ACK:
        begin
          s_nxt.lk = lcmd(1'b1, pis_pkg::W_IRQD, pis_pkg::IRQ_TO_DEV);
          s_nxt.st = pis_pkg::H_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  // Synchronous reset to idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r    <= '0;
      s_r.st <= pis_pkg::H_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign awready    = wr_go;
  assign wready     = wr_go;
  assign arready    = rd_go;
  assign bvalid     = s_r.bvalid;
  assign bresp      = s_r.bresp;
  assign rvalid     = s_r.rvalid;
  assign rresp      = s_r.rresp;
  assign rdata      = s_r.rdata;
  assign link.req   = s_r.lk.req;
  assign link.we    = s_r.lk.we;
  assign link.addr  = s_r.lk.addr;
  assign link.wdata = s_r.lk.wd;

endmodule // pis_hst_end

// >>> dv/pis_link_asserts.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Checks on the shared memory port between the two ends
module pis_link_asserts
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        req,
  input wire logic        we,
  input wire logic [2:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  logic [15:0] st_r, ot_r;     // Start and output words as last written
  logic        gs_r, rs_r;     // Grant as the host saw it, status read pending
  wire         wr = req && we;  // Host write strobe
  wire         rd = req && !we; // Host read strobe
  // Shadow of host writes and of the polled grant
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {st_r, ot_r, gs_r, rs_r} <= 34'h0;
    else
    begin
      rs_r <= rd && addr == pis_pkg::W_STAT;
      if (rs_r) gs_r <= rdata[15];
      if (wr && addr == pis_pkg::W_START && wdata[15] && !st_r[15]) gs_r <= 1'b0;
      if (wr && addr == pis_pkg::W_START) st_r <= wdata;
      if (wr && addr == pis_pkg::W_OUT) ot_r <= wdata;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  start_echo_a: assert property (rd && addr == pis_pkg::W_START |=> rdata == st_r)
    else $error("start word read back wrong");
  out_echo_a: assert property (rd && addr == pis_pkg::W_OUT |=> rdata == ot_r)
    else $error("output word read back wrong");
  dev_code_a: assert property (wr && addr == pis_pkg::W_IRQD |-> wdata == 16'h0020)
    else $error("wrong code toward device");
  host_code_a: assert property (rd && addr == pis_pkg::W_IRQH |=>
    rdata inside {16'h0, 16'h0010})
    else $error("wrong code toward host");
  mode_word_a: assert property (wr && addr == pis_pkg::W_MBOX |->
    wdata inside {16'h0750, 16'h0004, 16'h0001, 16'h2200, 16'h0600, 16'h0000})
    else $error("bad mode request word");
  grant_cause_a: assert property (rd && addr == pis_pkg::W_STAT ##1 rdata[15] && !gs_r
    |-> st_r[15])
    else $error("grant without request");
  img_wait_a: assert property (req && addr inside {3'h2, 3'h3} |-> !st_r[15] || gs_r)
    else $error("image touched before grant");
  out_hold_a: assert property (wr && addr == pis_pkg::W_OUT |-> st_r[15] == gs_r)
    else $error("output changed during release");
endmodule // pis_link_asserts

// >>> dv/tb_process_image_sync_handshake.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Both ends joined; the bench works the host registers
module tb_process_image_sync_handshake;
  logic        aclk = 1'b0, aresetn = 1'b0, bus_run = 1'b1, tmo_load = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, cycle_done, sync_err, pulse_mode;
  logic        lock_granted;
  logic [31:0] tmo_us = 32'd20, wdata = 32'h0, rdata, q;
  logic [15:0] field_in = 16'h1234, field_out;
  logic [4:0]  awaddr = 5'h0, araddr = 5'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, r;
  int          n_errors = 0, n_compared = 0, n;
  pis_link_if link ();
  pis_dev_end #(.CYCLE_CLKS(40)) u_pis_dev_end
  (.aclk, .aresetn, .link, .bus_run, .tmo_load, .tmo_us, .field_in, .field_out,
   .cycle_done, .sync_err, .pulse_mode, .lock_granted);
  pis_hst_end u_pis_hst_end
  (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
   .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .link);
  pis_link_asserts u_pis_link_asserts
  (.aclk, .aresetn, .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
   .rdata(link.rdata));
  // 25 MHz clock
  initial
    forever #20 aclk = ~aclk;
  // Counts, verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Ends the run when a bounded wait ran out
  task automatic guard(input logic ok);
    if (ok !== 1'b1)
    begin
      n_errors++;
      conclude();
    end
  endtask
  // One AXI4-Lite transfer, write when w is high; answer in q and r
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!(w ? bvalid : rvalid) && ++k < 600);
    guard(w ? bvalid : rvalid);
    q = rdata;
    r = w ? bresp : rresp;
  endtask
  // Waits for the end of the next bus cycle
  task automatic tick();
    int k;
    k = 0;
    do @(posedge aclk); while (cycle_done !== 1'b1 && ++k < 300);
    guard(cycle_done === 1'b1);
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    tmo_load <= 1'b1;
    @(posedge aclk);
    tmo_load <= 1'b0;
    acc(0, 5'h14, 0);
    check("unmapped data", q, 32'h0);
    check("unmapped resp", r, pis_pkg::RESP_SLVERR);
    acc(1, 5'h04, 32'h1);
    check("status write resp", r, pis_pkg::RESP_OKAY);
    acc(0, 5'h04, 0);
    check("grant bit", q[0], 1'b0);
    check("bus up", q[3], 1'b1);
    acc(1, 5'h08, 32'h2);
    tick();
    acc(0, 5'h0c, 0);
    check("free in", q, 32'h1234);
    acc(1, 5'h08, 32'h3);
    acc(1, 5'h0c, 32'h0a5a);
    tick();
    tick();
    check("free out", field_out, 32'h0a5a);
    acc(0, 5'h0c, 0);
    check("out word", q, 32'h0a5a);
    acc(1, 5'h08, 32'h2);
    acc(1, 5'h00, 32'h1);
    acc(0, 5'h0c, 0);
    check("lock in", q, 32'h1234);
    check("granted", lock_granted, 1'b1);
    field_in <= 16'h5678;
    tick();
    tick();
    acc(0, 5'h0c, 0);
    check("frozen in", q, 32'h1234);
    acc(1, 5'h08, 32'h0);
    acc(0, 5'h0c, 0);
    check("start word", q, 32'h8000);
    acc(1, 5'h08, 32'h3);
    acc(1, 5'h0c, 32'h00c3);
    tick();
    check("frozen out", field_out, 32'h0a5a);
    acc(1, 5'h00, 32'h0);
    tick();
    tick();
    check("taken out", field_out, 32'h00c3);
    check("released", lock_granted, 1'b0);
    acc(1, 5'h08, 32'h2);
    tick();
    acc(0, 5'h0c, 0);
    check("free again", q, 32'h5678);
    acc(1, 5'h00, 32'h2);
    n = 0;
    do @(posedge aclk); while (pulse_mode !== 1'b1 && ++n < 100);
    guard(n < 100);
    check("pulse on", pulse_mode, 1'b1);
    acc(1, 5'h08, 32'h3);
    tick();
    acc(1, 5'h0c, 32'h0077);
    n = 0;
    do acc(0, 5'h04, 0); while (q[1] !== 1'b1 && ++n < 20);
    guard(n < 20);
    check("irq seen", q[1], 1'b1);
    check("held out", field_out, 32'h00c3);
    acc(1, 5'h10, 0);
    tick();
    n = 0;
    do @(posedge aclk); while (sync_err !== 1'b1 && ++n < 400);
    guard(n < 400);
    check("app timeout", n > 224 && n < 254, 1'b1);
    check("pulse out", field_out, 32'h0077);
    acc(0, 5'h04, 0);
    check("irq again", q[1], 1'b1);
    n = 0;
    repeat (100) @(posedge aclk) n += cycle_done;
    check("halted", n, 0);
    acc(0, 5'h04, 0);
    check("bus down", q[3], 1'b0);
    conclude();
  end
endmodule // tb_process_image_sync_handshake
